// ### hw/aad_datapath.v
/*
 * accumulator alu datapath: 12-bit fetch, two-stage pipeline, 8-bit alu
 * with working accumulator and carry / digit carry / zero flags.
 * assumes a program memory that returns prog_data combinationally for
 * prog_addr, and an external general register file read combinationally
 * by file_addr; writes are single strobes in the fourth quarter-phase.
 */
// What this block does
// - fetch one 12-bit instruction word per cycle on a separate program bus.
// - fetch overlaps execute; instructions take one cycle, except branches, taken skips and pcl writes.
// - 8-bit alu doing add, subtract, shifts and logic operations.
// - arithmetic is two's complement unless the instruction says otherwise.
// - two-operand ops use accumulator plus a file register or literal.
// - single-operand ops act on the accumulator or a file register.
// - 8-bit working accumulator with no data-memory address.
// - alu updates carry, digit carry and zero in status per instruction.
// - in subtraction carry and digit carry act as borrow flags.
// - special registers, program counter low byte included, live in data memory.
// - any file operation may target any file register, directly or through fsr.
// - operand read in the second quarter, destination write in the fourth.
// - a taken branch flushes the prefetched word, costing two cycles.
`timescale 1ns/100ps
`include "aad_regs.vh"

module aad_datapath
#(
    parameter INSN_W = `AAD_INSN_W,
    parameter DATA_W = `AAD_DATA_W
)
(
    input  wire              clock,
    input  wire              rst_n,
    output reg  [11:0]       prog_addr,
    input  wire [INSN_W-1:0] prog_data,
    output reg  [4:0]        file_addr,
    input  wire [DATA_W-1:0] file_rdata,
    output reg  [DATA_W-1:0] file_wdata,
    output reg               file_we,
    output reg  [DATA_W-1:0] accum,
    output reg  [DATA_W-1:0] status,
    output reg  [1:0]        qphase,
    output reg               flushing
);

    // accumulator, status, fsr and pc are internal; status/fsr/pcl are file-mapped
    reg  [11:0]       pc;
    reg  [INSN_W-1:0] ir;
    reg  [DATA_W-1:0] fsr;
    reg  [DATA_W-1:0] operand;
    reg  [DATA_W-1:0] res;
    reg               res_c;
    reg               res_dc;
    reg               upd_c;
    reg               upd_dc;
    reg               upd_z;
    reg               to_file;
    reg               to_w;
    reg               branch;
    reg  [11:0]       target;
    reg               skip;
    reg  [4:0]        eff_addr;
    reg  [DATA_W-1:0] rd_val;

    wire [4:0]        f_field = ir[4:0];
    wire              d_bit   = ir[5];
    wire [7:0]        lit     = ir[7:0];

    // add with carry-in; sub uses a + ~b + 1 so carry set means no borrow
    function [9:0] alu_add;
        input [7:0] a;
        input [7:0] b;
        input       cin;
        reg   [8:0] s;
        reg   [4:0] n;
        begin
            s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            alu_add = {s[8], n[4], s[7:0]};
        end
    endfunction

    // indirect access through fsr when the field names the indirect slot
    always @*
    begin
        eff_addr = (f_field == `AAD_ADDR_INDF) ? fsr[4:0] : f_field;
        if (eff_addr == `AAD_ADDR_STATUS)
            rd_val = status;
        else if (eff_addr == `AAD_ADDR_FSR)
            rd_val = fsr;
        else if (eff_addr == `AAD_ADDR_PCL)
            rd_val = pc[7:0];
        else if (eff_addr == `AAD_ADDR_INDF)
            rd_val = 8'h00;
        else
            rd_val = file_rdata;
    end

    // decode and execute the latched word
    always @*
    begin
        res = 8'h00;
        res_c = status[`AAD_STAT_C];
        res_dc = status[`AAD_STAT_DIGIT];
        upd_c = 1'b0;
        upd_dc = 1'b0;
        upd_z = 1'b0;
        to_file = 1'b0;
        to_w = 1'b0;
        branch = 1'b0;
        target = pc;
        skip = 1'b0;
        if (ir[11:10] == 2'b00)
        begin
            // byte-oriented file ops: result to accumulator or file by d
            to_file = d_bit && (ir[9:6] != 4'h0 || ir[5]);
            to_w = !d_bit && ir[9:6] != 4'h0;
            case (ir[9:6])
                4'h0:
                begin
                    res = accum; // move accumulator to file
                    to_file = d_bit;
                end
                4'h1:
                begin
                    res = 8'h00; // clear
                    upd_z = 1'b1;
                end
                4'h2:
                begin
                    {res_c, res_dc, res} = alu_add(operand, ~accum, 1'b1);
                    upd_c = 1'b1;
                    upd_dc = 1'b1;
                    upd_z = 1'b1;
                end
                4'h3:
                begin
                    res = operand - 8'h01;
                    upd_z = 1'b1;
                end
                4'h4:
                begin
                    res = accum | operand;
                    upd_z = 1'b1;
                end
                4'h5:
                begin
                    res = accum & operand;
                    upd_z = 1'b1;
                end
                4'h6:
                begin
                    res = accum ^ operand;
                    upd_z = 1'b1;
                end
                4'h7:
                begin
                    {res_c, res_dc, res} = alu_add(accum, operand, 1'b0);
                    upd_c = 1'b1;
                    upd_dc = 1'b1;
                    upd_z = 1'b1;
                end
                4'h8:
                begin
                    res = operand;
                    upd_z = 1'b1;
                end
                4'h9:
                begin
                    res = ~operand;
                    upd_z = 1'b1;
                end
                4'hA:
                begin
                    res = operand + 8'h01;
                    upd_z = 1'b1;
                end
                4'hB:
                begin
                    res = operand - 8'h01;
                    skip = (res == 8'h00);
                end
                4'hC:
                begin
                    res = {status[`AAD_STAT_C], operand[7:1]};
                    res_c = operand[0];
                    upd_c = 1'b1;
                end
                4'hD:
                begin
                    res = {operand[6:0], status[`AAD_STAT_C]};
                    res_c = operand[7];
                    upd_c = 1'b1;
                end
                4'hE:
                begin
                    res = {operand[3:0], operand[7:4]};
                end
                default:
                begin
                    res = operand + 8'h01;
                    skip = (res == 8'h00);
                end
            endcase
        end
        else if (ir[11:10] == 2'b01)
        begin
            // bit ops: clear, set, test-and-skip
            to_file = !ir[9];
            res = ir[8] ? (operand | (8'h01 << ir[7:5])) : (operand & ~(8'h01 << ir[7:5]));
            if (ir[9])
                skip = operand[ir[7:5]] ^ ir[8];
        end
        else if (ir[11:10] == 2'b10)
        begin
            branch = 1'b1;
            target = ir[9] ? {3'b000, ir[8:0]} : {4'h0, ir[7:0]};
            if (!ir[9])
            begin
                res = lit; // literal jump also loads accumulator
                to_w = 1'b1;
            end
        end
        else
        begin
            to_w = 1'b1;
            case (ir[9:8])
                2'b00: res = lit;
                2'b01: res = accum | lit;
                2'b10: res = accum & lit;
                default: res = accum ^ lit;
            endcase
            upd_z = (ir[9:8] != 2'b00);
        end
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            qphase <= `AAD_Q1;
            pc <= `AAD_PC_RESET;
            prog_addr <= `AAD_PC_RESET;
            ir <= `AAD_NOP;
            accum <= `AAD_W_RESET;
            status <= `AAD_STAT_RESET;
            fsr <= `AAD_FSR_RESET;
            operand <= 8'h00;
            file_addr <= 5'h00;
            file_wdata <= 8'h00;
            file_we <= 1'b0;
            flushing <= 1'b0;
        end
        else
        begin
            qphase <= qphase + 2'b01;
            file_we <= 1'b0;
            case (qphase)
                `AAD_Q1:
                begin
                    pc <= pc + 12'h001;
                    file_addr <= eff_addr;
                end
                `AAD_Q2:
                    operand <= rd_val;
                `AAD_Q3:
                begin
                    // assemble write-back so the file strobe lands in the fourth quarter
                    file_wdata <= res;
                    file_we <= to_file && eff_addr != `AAD_ADDR_STATUS
                               && eff_addr != `AAD_ADDR_FSR && eff_addr != `AAD_ADDR_PCL
                               && eff_addr != `AAD_ADDR_INDF && !flushing;
                end
                default:
                begin
                    if (!flushing)
                    begin
                        if (to_w)
                            accum <= res;
                        if (upd_c)
                            status[`AAD_STAT_C] <= res_c;
                        if (upd_dc)
                            status[`AAD_STAT_DIGIT] <= res_dc;
                        if (upd_z)
                            status[`AAD_STAT_Z] <= (res == 8'h00);
                        if (to_file && eff_addr == `AAD_ADDR_STATUS)
                            status <= {res[7:3], status[2:0]};
                        if (to_file && eff_addr == `AAD_ADDR_FSR)
                            fsr <= res;
                    end
                    // branch or skip or pcl write discards the prefetched word
                    if (!flushing && (branch || skip
                        || (to_file && eff_addr == `AAD_ADDR_PCL)))
                    begin
                        flushing <= 1'b1;
                        if (branch)
                        begin
                            pc <= target;
                            prog_addr <= target;
                        end
                        else if (!skip)
                        begin
                            pc <= {pc[11:8], res};
                            prog_addr <= {pc[11:8], res};
                        end
                        else
                            prog_addr <= pc;
                    end
                    else
                    begin
                        flushing <= 1'b0;
                        prog_addr <= pc;
                    end
                    ir <= prog_data;
                end
            endcase
        end
    end

endmodule

// ### hw/aad_regs.vh
/*
 * constants for the accumulator alu datapath: widths, file addresses,
 * status bit positions, reset values and quarter-phase codes.
 * assumes inclusion by bare name from the datapath module.
 */
`ifndef AAD_REGS_VH
`define AAD_REGS_VH

`define AAD_INSN_W        12
`define AAD_DATA_W        8
`define AAD_FADDR_W       5
`define AAD_PC_W          12
`define AAD_PC_RESET      12'hFFF
`define AAD_W_RESET       8'h00
`define AAD_STAT_RESET    8'h18
`define AAD_FSR_RESET     8'h00
`define AAD_ADDR_INDF     5'h00
`define AAD_ADDR_PCL      5'h02
`define AAD_ADDR_STATUS   5'h03
`define AAD_ADDR_FSR      5'h04
`define AAD_STAT_C        0
`define AAD_STAT_DIGIT    1
`define AAD_STAT_Z        2
`define AAD_Q1            2'b00
`define AAD_Q2            2'b01
`define AAD_Q3            2'b10
`define AAD_Q4            2'b11
`define AAD_NOP           12'h000

`endif

// ### verif/aad_datapath_properties.sv
/* port checker for the accumulator alu datapath.
   assumes it is bound onto aad_datapath and sees only its ports. */
`timescale 1ns/100ps
module aad_chk
(
    input wire        clock,
    input wire        rst_n,
    input wire [11:0] prog_addr,
    input wire [4:0]  file_addr,
    input wire        file_we,
    input wire [7:0]  accum,
    input wire [1:0]  qphase,
    input wire        flushing
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    phase_step_a: assert property (rst_n |=> qphase == $past(qphase) + 2'h1)
        else $error("quarter phase did not advance by one");
    we_pulse_a: assert property (file_we |=> !file_we)
        else $error("write strobe longer than one clock");
    we_quarter_a: assert property (file_we |-> qphase == 2'h3)
        else $error("write strobe outside the fourth quarter");
    we_internal_a: assert property (file_we |-> !(file_addr inside {5'h00, 5'h02, 5'h03, 5'h04}))
        else $error("special register write leaked to the file bus");
    fetch_edge_a: assert property (!$stable(prog_addr) |-> $past(qphase) == 2'h3)
        else $error("program address moved outside the fetch edge");
    fetch_step_a: assert property (!$stable(prog_addr) && !$rose(flushing)
        |-> prog_addr == $past(prog_addr) + 12'h001)
        else $error("program address skipped without a branch");
    acc_edge_a: assert property (!$stable(accum) |-> $past(qphase) == 2'h3)
        else $error("accumulator changed mid cycle");
    flush_len_a: assert property ($rose(flushing)
        |-> (qphase == 2'h0) ##0 flushing[*4] ##1 !flushing)
        else $error("discarded cycle not exactly one instruction long");
    flush_quiet_a: assert property (flushing |-> !file_we)
        else $error("discarded word wrote the file");
endmodule

bind aad_datapath aad_chk u_chk
(
    .clock     (clock),
    .rst_n     (rst_n),
    .prog_addr (prog_addr),
    .file_addr (file_addr),
    .file_we   (file_we),
    .accum     (accum),
    .qphase    (qphase),
    .flushing  (flushing)
);

// ### verif/aad_mem_model.sv
/* program memory and general register file model.
   assumes the datapath reads both combinationally and strobes writes. */
`timescale 1ns/100ps
module aad_mem_model
(
    input  wire        clock,
    input  wire [11:0] prog_addr,
    output wire [11:0] prog_data,
    input  wire [4:0]  file_addr,
    output wire [7:0]  file_rdata,
    input  wire [7:0]  file_wdata,
    input  wire        file_we
);
    logic [11:0] prog [0:4095];
    logic [7:0]  rf   [0:31];

    assign prog_data  = prog[prog_addr];
    assign file_rdata = rf[file_addr];
    always @(posedge clock)
    begin
        if (file_we)
            rf[file_addr] <= file_wdata;
    end
endmodule

// ### verif/tb_top.sv
/* self-checking bench: short programs run from the memory model.
   assumes the memory model and the bound port checker. */
`timescale 1ns/100ps
module tb_top;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    wire  [11:0] prog_addr;
    wire  [11:0] prog_data;
    wire  [4:0]  file_addr;
    wire  [7:0]  file_rdata;
    wire  [7:0]  file_wdata;
    wire         file_we;
    wire  [7:0]  accum;
    wire  [7:0]  status;
    wire  [1:0]  qphase;
    wire         flushing;
    int          n_errors = 0;
    int          compares = 0;
    int          pc_wr;

    always #4 clock = ~clock;

    aad_datapath DUT (.clock(clock), .rst_n(rst_n), .prog_addr(prog_addr),
        .prog_data(prog_data), .file_addr(file_addr), .file_rdata(file_rdata),
        .file_wdata(file_wdata), .file_we(file_we), .accum(accum),
        .status(status), .qphase(qphase), .flushing(flushing));
    aad_mem_model mem (.clock(clock), .prog_addr(prog_addr), .prog_data(prog_data),
        .file_addr(file_addr), .file_rdata(file_rdata), .file_wdata(file_wdata),
        .file_we(file_we));

    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task results;
        if (n_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task clear;
        for (int i = 0; i < 4096; i++)
            mem.prog[i] = 12'h000;
        for (int i = 0; i < 32; i++)
            mem.rf[i] = 8'h00;
        pc_wr = 0;
    endtask

    task put(input logic [11:0] w);
        mem.prog[pc_wr] = w;
        pc_wr++;
    endtask

    // every program ends in a jump to itself, so a fixed cycle count settles it
    // reset is already low at the very start, so only a rerun needs the extra edge
    task run(input int ncyc);
        if (rst_n)
        begin
            @(posedge clock);
            rst_n <= 1'b0;
        end
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk("reset pc", prog_addr, 12'hFFF);
        chk("reset w", accum, 8'h00);
        chk("reset status", status, 8'h18);
        repeat (4 * ncyc) @(posedge clock);
        #1;
    endtask

    task t_add;
        clear;
        put(12'hC8F);
        put(12'h030);
        put(12'hC71);
        put(12'h1D0);
        put(12'hA04);
        run(9);
        chk("add w", accum, 8'h00);
        chk("add status", status, 8'h1F);
        chk("add file", mem.rf[16], 8'h8F);
    endtask

    task t_sub;
        clear;
        mem.rf[16] = 8'h15;
        mem.rf[17] = 8'h35;
        put(12'hC12);
        put(12'h0B1);
        put(12'hC21);
        put(12'h090);
        put(12'hA04);
        run(9);
        chk("sub file", mem.rf[17], 8'h23);
        chk("sub w", accum, 8'hF4);
        chk("sub status", status, 8'h1A);
    endtask

    // rotate result feeds the logic ops, so a wrong carry shows at the end
    task t_logic;
        clear;
        mem.rf[18] = 8'h81;
        put(12'h352);
        put(12'h312);
        put(12'hEF0);
        put(12'hFC0);
        put(12'hD03);
        put(12'hA05);
        run(10);
        chk("logic w", accum, 8'h03);
        chk("logic status", status, 8'h19);
        chk("rotate src kept", mem.rf[18], 8'h81);
    endtask

    // skipped and discarded words store to 20..22, so a missed flush shows there
    task t_file_ops;
        clear;
        mem.rf[16] = 8'h12;
        mem.rf[17] = 8'h01;
        mem.rf[19] = 8'hAA;
        put(12'hC11);
        put(12'h024);
        put(12'h2E0);
        put(12'h034);
        put(12'h3B0);
        put(12'h270);
        put(12'h5F2);
        put(12'h6F2);
        put(12'h035);
        put(12'h073);
        put(12'h80C);
        put(12'h036);
        put(12'h0D2);
        put(12'h090);
        put(12'hA0E);
        run(24);
        chk("indirect dec", mem.rf[17], 8'h00);
        chk("swap comp file", mem.rf[16], 8'hDE);
        chk("bit set file", mem.rf[18], 8'h80);
        chk("clear file", mem.rf[19], 8'h00);
        chk("skipped words", mem.rf[20] | mem.rf[21] | mem.rf[22], 8'h00);
        chk("borrow w", accum, 8'h5F);
        chk("borrow status", status, 8'h19);
    endtask

    task automatic t_branch;
        int k;
        clear;
        mem.rf[3] = 8'h5A;
        put(12'hC05);
        put(12'hA03);
        put(12'hC77);
        put(12'h034);
        put(12'hCE0);
        put(12'h023);
        put(12'hA06);
        run(12);
        chk("branch w", accum, 8'hE0);
        chk("branch file", mem.rf[20], 8'h05);
        chk("status write", status, 8'hE0);
        chk("status not on bus", mem.rf[3], 8'h5A);
        for (k = 0; k < 16 && flushing !== 1'b1; k++)
        begin
            @(posedge clock);
            #1;
        end
        chk("flush seen", flushing, 1'b1);
        if (flushing !== 1'b1)
            results;
    endtask

    initial
    begin
        t_add;
        t_sub;
        t_logic;
        t_file_ops;
        t_branch;
        results;
    end
endmodule
